// ==== pkg/ecr_pkg.sv ====
// Constants and types for the exception cause register block
package ecr_pkg;
	// ----------------------------------------
	// Register map (word aligned byte offsets)
	// ----------------------------------------
	localparam logic [3:0] ECR_OFS_CAUSE = 4'h0;
	localparam logic [3:0] ECR_OFS_STATUS = 4'h4;
	localparam logic [3:0] ECR_OFS_RESUME = 4'h8;
	// ----------------------------------------
	// Cause register fields
	// ----------------------------------------
	localparam int ECR_DS_BIT = 31;
	localparam int ECR_UNIT_LSB = 28;
	localparam int ECR_IP_LSB = 8;
	localparam int ECR_CODE_LSB = 2;
	localparam int ECR_SW_IRQ_W = 2;
	localparam int ECR_HW_IRQ_W = 6;
	localparam int ECR_IP_W = 8;
	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int ECR_IE_BIT = 0;
	localparam int ECR_MASK_LSB = 8;
	localparam int ECR_WIDE_BIT = 31;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [4:0] ECR_CODE_RST = 5'h00;
	localparam logic [1:0] ECR_UNIT_RST = 2'h0;
	localparam logic [1:0] ECR_SW_IRQ_RST = 2'h0;
	localparam logic [7:0] ECR_MASK_RST = 8'h00;
	localparam logic [31:0] ECR_RESUME_RST = 32'h00000000;
	localparam logic [31:0] ECR_ZERO_WORD = 32'h00000000;
	// ----------------------------------------
	// Exception codes
	// ----------------------------------------
	localparam logic [4:0] ECR_INTERRUPT_CODE = 5'h00;
	localparam logic [4:0] ECR_UNMODIFIED_WRITE_CODE = 5'h01;
	localparam logic [4:0] ECR_MAP_MISS_LOAD_CODE = 5'h02;
	localparam logic [4:0] ECR_MAP_MISS_STORE_CODE = 5'h03;
	localparam logic [4:0] ECR_MISALIGNED_LOAD_CODE = 5'h04;
	localparam logic [4:0] ECR_MISALIGNED_STORE_CODE = 5'h05;
	localparam logic [4:0] ECR_FETCH_BUS_FAULT_CODE = 5'h06;
	localparam logic [4:0] ECR_LOAD_STORE_BUS_FAULT_CODE = 5'h07;
	localparam logic [4:0] ECR_SYSCALL_CODE = 5'h08;
	localparam logic [4:0] ECR_BREAK_CODE = 5'h09;
	localparam logic [4:0] ECR_UNDEFINED_OPCODE_CODE = 5'h0A;
	localparam logic [4:0] ECR_UNIT_UNUSABLE_CODE = 5'h0B;
	localparam logic [4:0] ECR_ARITH_CARRY_FAULT_CODE = 5'h0C;
	localparam logic [4:0] ECR_CONDITIONAL_FAULT_CODE = 5'h0D;
	localparam logic [4:0] ECR_COHERENCY_FETCH_CODE = 5'h0E;
	localparam logic [4:0] ECR_FLOAT_FAULT_CODE = 5'h0F;
	localparam logic [4:0] ECR_WATCH_MATCH_CODE = 5'h17;
	localparam logic [4:0] ECR_COHERENCY_DATA_CODE = 5'h1F;
	localparam logic [4:0] ECR_NARROW_LAST_CODE = 5'h0C;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [0:0] {
		ECR_BUS_IDLE = 1'b0,
		ECR_BUS_ANSWER = 1'b1
	} ecr_bus_state_t;

	typedef struct packed {
		logic valid;
		logic [4:0] code;
		logic inDelaySlot;
		logic [1:0] unit;
		logic [31:0] pc;
		logic [31:0] branchPc;
	} ecr_exc_t;
endpackage

// ==== hw/ecr_cause_unit.sv ====
// Exception cause register with Avalon-MM register access
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

// Behaviour
// - A 32-bit software readable and writable cause register records the latest exception.
// - Delay-slot flag is one when the fault sat in a branch delay slot.
// - Unit number field, bits 29:28, loads on a coprocessor unusable exception.
// - Pending interrupt field at bits 15:8; its two low bits software writable.
// - Upper six pending bits are read only and follow the interrupt requests.
// - Exception code field sits in bits 5 down to 2.
// - Unused cause bits ignore writes and read as zero.
// - Codes 0 to 3: interrupt, unmodified write, miss on load, miss on store.
// - Address error on load or fetch is code 4, on store code 5.
// - Codes 6 to 12 as listed; 13 to 31 reserved in narrow variant.
// - Later variant widens the code field to five bits, layout otherwise unchanged.
// - Later variant adds trap 13, coherency fetch 14, floating point 15.
// - Later variant adds watch match 23 and coherency data 31.
// - Interrupt request when enabled and any pending bit meets its mask bit.
// - In a delay slot the resume address is the preceding branch address.
module ecr_cause_unit
	import ecr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic [1:0] response,
	output logic waitrequest,
	// Pipeline exception report
	input wire ecr_exc_t excIn,
	// Interrupt request pins
	input wire logic [5:0] hwIrqPin,
	// Interrupt request to the pipeline
	output logic irqRequest
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic [4:0] fitCode(input logic [4:0] code, input logic wide);
		fitCode = wide ? code : {1'b0, code[3:0]};
	endfunction

	function automatic logic isMapped(input logic [3:0] addr);
		isMapped = (addr == ECR_OFS_CAUSE) || (addr == ECR_OFS_STATUS) || (addr == ECR_OFS_RESUME);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	ecr_bus_state_t busState_q;
	ecr_bus_state_t busState_d;
	logic [31:0] readdata_q;
	logic [1:0] response_q;
	logic [4:0] code_q;
	logic dsFlag_q;
	logic [1:0] unit_q;
	logic [1:0] swIrq_q;
	logic [7:0] irqMask_q;
	logic intEnable_q;
	logic wideCode_q;
	logic [31:0] resume_q;
	logic [5:0] hwMeta_q;
	logic [5:0] hwSync_q;

	// ----------------------------------------
	// Interrupt pin synchronisers
	// ----------------------------------------
	// Pins are asynchronous to clk; only the second stage feeds logic
	genvar gi;
	generate
		for (gi = 0; gi < ECR_HW_IRQ_W; gi++)
		begin : gSync
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					hwMeta_q[gi] <= 1'b0;
					hwSync_q[gi] <= 1'b0;
				end
				else
				begin
					hwMeta_q[gi] <= hwIrqPin[gi];
					hwSync_q[gi] <= hwMeta_q[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire busReq = read | write;
	wire busDone = (busState_q == ECR_BUS_ANSWER);
	wire wrDone = busDone & write;
	wire wrCause = wrDone & (address == ECR_OFS_CAUSE);
	wire wrStatus = wrDone & (address == ECR_OFS_STATUS);
	wire excTake = excIn.valid;
	wire [4:0] excCodeFit = fitCode(excIn.code, wideCode_q);
	wire excUnusable = (excCodeFit == ECR_UNIT_UNUSABLE_CODE);
	wire [7:0] pendingBits = {hwSync_q, swIrq_q};
	wire [4:0] codeShown = wideCode_q ? code_q : {1'b0, code_q[3:0]};
	wire [31:0] causeWord = {dsFlag_q, 1'b0, unit_q, 12'h000, pendingBits, 1'b0, codeShown, 2'h0};
	wire [31:0] statusWord = {wideCode_q, 15'h0000, irqMask_q, 7'h00, intEnable_q};
	wire [31:0] readSel = (address == ECR_OFS_CAUSE) ? causeWord :
		(address == ECR_OFS_STATUS) ? statusWord :
		(address == ECR_OFS_RESUME) ? resume_q : ECR_ZERO_WORD;

	// Every access costs two cycles; readdata is registered for timing
	assign busState_d = (busReq && !busDone) ? ECR_BUS_ANSWER : ECR_BUS_IDLE;
	assign waitrequest = busReq & ~busDone;
	assign readdata = readdata_q;
	assign response = response_q;
	assign irqRequest = intEnable_q & |(pendingBits & irqMask_q);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busState_q <= ECR_BUS_IDLE;
			readdata_q <= ECR_ZERO_WORD;
			response_q <= 2'h0;
		end
		else
		begin
			busState_q <= busState_d;
			readdata_q <= (read && !busDone) ? readSel : ECR_ZERO_WORD;
			response_q <= (busReq && !busDone && !isMapped(address)) ? 2'h2 : 2'h0;
		end
	end

	// ----------------------------------------
	// Software writable fields
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			swIrq_q <= ECR_SW_IRQ_RST;
			irqMask_q <= ECR_MASK_RST;
			intEnable_q <= 1'b0;
			wideCode_q <= 1'b0;
		end
		else
		begin
			if (wrCause && byteenable[1])
				swIrq_q <= writedata[ECR_IP_LSB +: ECR_SW_IRQ_W];
			if (wrStatus && byteenable[0])
				intEnable_q <= writedata[ECR_IE_BIT];
			if (wrStatus && byteenable[1])
				irqMask_q <= writedata[ECR_MASK_LSB +: ECR_IP_W];
			if (wrStatus && byteenable[3])
				wideCode_q <= writedata[ECR_WIDE_BIT];
		end
	end

	// ----------------------------------------
	// Exception capture
	// ----------------------------------------
	// Code, flag and resume load on one edge, the unit too on an unusable code, so a read never sees a torn record
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			code_q <= ECR_CODE_RST;
			dsFlag_q <= 1'b0;
			unit_q <= ECR_UNIT_RST;
			resume_q <= ECR_RESUME_RST;
		end
		else if (excTake)
		begin
			code_q <= excCodeFit;
			dsFlag_q <= excIn.inDelaySlot;
			if (excUnusable)
				unit_q <= excIn.unit;
			resume_q <= excIn.inDelaySlot ? excIn.branchPc : excIn.pc;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	code_capture_a: assert property (excIn.valid |=> code_q == fitCode($past(excIn.code), $past(wideCode_q)))
		else $error("code not captured");

	ds_flag_a: assert property (excIn.valid |=> dsFlag_q == $past(excIn.inDelaySlot))
		else $error("delay slot flag wrong");

	unit_load_a: assert property (excIn.valid && excUnusable |=> causeWord[29:28] == $past(excIn.unit))
		else $error("unit number not loaded");

	unit_hold_a: assert property (excIn.valid && !excUnusable |=> $stable(unit_q))
		else $error("unit number changed");

	sw_irq_a: assert property (wrCause && byteenable[1] |=> causeWord[9:8] == $past(writedata[9:8]))
		else $error("software irq write lost");

	hw_irq_a: assert property (causeWord[15:10] == hwSync_q)
		else $error("hardware pending bits wrong");

	code_field_a: assert property (causeWord[5:2] == code_q[3:0])
		else $error("code field misplaced");

	reserved_zero_a: assert property (causeWord[30] == 1'b0 && causeWord[27:16] == 12'h000 && causeWord[1:0] == 2'h0)
		else $error("reserved bits not zero");

	narrow_code_a: assert property (!wideCode_q |-> causeWord[7:6] == 2'h0)
		else $error("narrow code overflow");

	wide_code_a: assert property (wideCode_q |-> causeWord[6:2] == code_q)
		else $error("wide code field wrong");

	irq_req_a: assert property (intEnable_q && |(pendingBits & irqMask_q) |-> irqRequest)
		else $error("interrupt not raised");

	resume_a: assert property (excIn.valid && excIn.inDelaySlot |=> resume_q == $past(excIn.branchPc))
		else $error("resume address wrong");

	bus_answer_a: assert property (busReq && !busDone |=> !waitrequest)
		else $error("bus answer late");

	read_idle_a: assert property (!busDone |-> readdata == ECR_ZERO_WORD)
		else $error("read data not cleared");

	read_data_a: assert property (read && !busDone |=> readdata == $past(readSel))
		else $error("read data wrong");

	slave_error_a: assert property (busReq && !busDone && !isMapped(address) |=> response == 2'h2)
		else $error("unmapped access not flagged");

	okay_resp_a: assert property (busReq && !busDone && isMapped(address) |=> response == 2'h0)
		else $error("mapped access flagged");

	wait_first_a: assert property (busReq && !busDone |-> waitrequest)
		else $error("request answered early");

	code_hold_a: assert property (!excIn.valid |=> $stable(code_q))
		else $error("code changed without exception");

	ds_hold_a: assert property (!excIn.valid |=> $stable(dsFlag_q))
		else $error("delay slot flag changed");

	resume_hold_a: assert property (!excIn.valid |=> $stable(resume_q))
		else $error("resume address changed");

	resume_pc_a: assert property (excIn.valid && !excIn.inDelaySlot |=> resume_q == $past(excIn.pc))
		else $error("resume address not fault address");

	sw_hold_a: assert property (!(wrCause && byteenable[1]) |=> $stable(swIrq_q))
		else $error("software irq bits changed");

	hw_follow_a: assert property (causeWord[15:10] == $past(hwIrqPin, 2))
		else $error("pending bits do not follow pins");

	irq_off_a: assert property (!intEnable_q |-> !irqRequest)
		else $error("interrupt while disabled");

	irq_mask_a: assert property (!(|(pendingBits & irqMask_q)) |-> !irqRequest)
		else $error("interrupt without masked pending bit");

	reserved_low_a: assert property (causeWord[7] == 1'b0)
		else $error("bit seven not zero");

	mask_write_a: assert property (wrStatus && byteenable[1] |=> irqMask_q == $past(writedata[15:8]))
		else $error("mask write lost");

	enable_write_a: assert property (wrStatus && byteenable[0] |=> intEnable_q == $past(writedata[0]))
		else $error("enable write lost");

	wide_write_a: assert property (wrStatus && byteenable[3] |=> wideCode_q == $past(writedata[31]))
		else $error("variant write lost");

	narrow_capture_a: assert property (excIn.valid && !wideCode_q |=> code_q[4] == 1'b0)
		else $error("narrow code kept fifth bit");

	together_a: assert property (excIn.valid && excUnusable |=> code_q == ECR_UNIT_UNUSABLE_CODE && dsFlag_q == $past(excIn.inDelaySlot) && unit_q == $past(excIn.unit))
		else $error("fields not updated together");

	status_zero_a: assert property (statusWord[30:16] == 15'h0000 && statusWord[7:1] == 7'h00)
		else $error("status reserved bits not zero");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	cov_delay_slot_c: cover property (excIn.valid && excIn.inDelaySlot);
	cov_unusable_c: cover property (excIn.valid && excUnusable);
	cov_irq_c: cover property (!irqRequest ##1 irqRequest);
	cov_read_c: cover property (read && busDone);
	cov_wide_c: cover property (excIn.valid && wideCode_q && excIn.code[4]);
endmodule

// ==== tb/ecr_pipe_model.sv ====
// Pipeline and interrupt source model feeding the cause unit
`timescale 1ns/1ps
module ecr_pipe_model
	import ecr_pkg::*;
(
	// Clock
	input wire logic clk,
	// Toward the cause unit
	output ecr_exc_t excOut,
	output logic [5:0] hwIrqPin
);
	initial
	begin
		excOut = '0;
		hwIrqPin = 6'h00;
	end

	task automatic takeFault(input logic [4:0] code, input logic ds, input logic [1:0] unit, input logic [31:0] pc);
		ecr_exc_t rel;
		@(posedge clk);
		excOut <= '{valid: 1'b1, code: code, inDelaySlot: ds, unit: unit, pc: pc, branchPc: pc - 32'h00000004};
		@(posedge clk);
		// Stale fields are scrambled so nothing leans on them
		rel = ~excOut;
		rel.valid = 1'b0;
		excOut <= rel;
	endtask

	task automatic setIrq(input logic [5:0] lines);
		@(posedge clk);
		hwIrqPin <= lines;
	endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the exception cause unit
`timescale 1ns/1ps
module tb
	import ecr_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata;
	logic [1:0] response;
	logic waitrequest;
	logic irqRequest;
	ecr_exc_t excIn;
	logic [5:0] hwIrqPin;
	logic [31:0] rdData;
	logic [1:0] rdResp;
	logic [4:0] wideCodes [5] = '{ECR_CONDITIONAL_FAULT_CODE, ECR_COHERENCY_FETCH_CODE, ECR_FLOAT_FAULT_CODE,
		ECR_WATCH_MATCH_CODE, ECR_COHERENCY_DATA_CODE};
	int failCount = 0;
	int comparisons = 0;

	always #4 clk = ~clk;

	ecr_cause_unit i_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .response(response),
		.waitrequest(waitrequest), .excIn(excIn), .hwIrqPin(hwIrqPin), .irqRequest(irqRequest));
	ecr_pipe_model i_pipe (.clk(clk), .excOut(excIn), .hwIrqPin(hwIrqPin));

	// ----------------------------------------
	// Bus access and comparison
	// ----------------------------------------
	// Request holds until an edge samples waitrequest low; read data is taken at that edge
	task automatic busAccess(input logic wr, input logic [3:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge clk);
		address <= addr;
		write <= wr;
		read <= ~wr;
		byteenable <= 4'hF;
		writedata <= data;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		rdData = readdata;
		rdResp = response;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0)
		begin
			failCount++;
			$display("wrong value at %0t: bus answer missing", $time);
		end
	endtask

	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic checkBit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			failCount++;
			$display("wrong value at %0t: irq line %b expected %b", $time, got, exp);
		end
	endtask

	task automatic readExpect(input logic [3:0] addr, input logic [31:0] exp);
		busAccess(1'b0, addr, ECR_ZERO_WORD);
		checkWord(rdData, exp);
		checkWord({30'h0, rdResp}, ECR_ZERO_WORD);
	endtask

	task automatic irqExpect(input logic exp);
		@(negedge clk);
		checkBit(irqRequest, exp);
	endtask

	function automatic logic [31:0] mkCause(input logic ds, input logic [1:0] unit, input logic [7:0] ip,
		input logic [4:0] code);
		return {ds, 1'b0, unit, 12'h000, ip, 1'b0, code, 2'h0};
	endfunction

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		readExpect(ECR_OFS_CAUSE, ECR_ZERO_WORD);
		readExpect(ECR_OFS_STATUS, ECR_ZERO_WORD);
		readExpect(ECR_OFS_RESUME, ECR_ZERO_WORD);
		busAccess(1'b0, 4'hC, ECR_ZERO_WORD);
		checkWord(rdData, ECR_ZERO_WORD);
		checkWord({30'h0, rdResp}, 32'h00000002);
		// Software bits alone take the all-ones write
		busAccess(1'b1, ECR_OFS_CAUSE, 32'hFFFFFFFF);
		readExpect(ECR_OFS_CAUSE, 32'h00000300);
		busAccess(1'b1, ECR_OFS_STATUS, 32'h00000100);
		irqExpect(1'b0);
		busAccess(1'b1, ECR_OFS_STATUS, 32'h00000201);
		irqExpect(1'b1);
		busAccess(1'b1, ECR_OFS_CAUSE, ECR_ZERO_WORD);
		irqExpect(1'b0);
		// Every narrow code, unit loads only on code 11 and holds for code 12
		for (int c = 0; c <= 12; c++)
		begin
			i_pipe.takeFault(5'(c), 1'b0, 2'h1, 32'h00001000 + 32'(c));
			readExpect(ECR_OFS_CAUSE, mkCause(1'b0, (c >= 11) ? 2'h1 : 2'h0, 8'h00, 5'(c)));
			readExpect(ECR_OFS_RESUME, 32'h00001000 + 32'(c));
		end
		i_pipe.takeFault(ECR_UNIT_UNUSABLE_CODE, 1'b1, 2'h2, 32'h00002000);
		readExpect(ECR_OFS_CAUSE, mkCause(1'b1, 2'h2, 8'h00, 5'h0B));
		readExpect(ECR_OFS_RESUME, 32'h00001FFC);
		i_pipe.takeFault(ECR_MISALIGNED_STORE_CODE, 1'b0, 2'h3, 32'h00003000);
		readExpect(ECR_OFS_CAUSE, mkCause(1'b0, 2'h2, 8'h00, 5'h05));
		// Narrow mode keeps four code bits only
		i_pipe.takeFault(ECR_WATCH_MATCH_CODE, 1'b0, 2'h0, 32'h00004000);
		readExpect(ECR_OFS_CAUSE, mkCause(1'b0, 2'h2, 8'h00, 5'h07));
		busAccess(1'b1, ECR_OFS_STATUS, 32'h80000000);
		foreach (wideCodes[k])
		begin
			i_pipe.takeFault(wideCodes[k], 1'b0, 2'h0, 32'h00005000);
			readExpect(ECR_OFS_CAUSE, mkCause(1'b0, 2'h2, 8'h00, wideCodes[k]));
		end
		// Interrupt lines reach the pending field after synchronising
		i_pipe.setIrq(6'h09);
		repeat (4) @(posedge clk);
		readExpect(ECR_OFS_CAUSE, mkCause(1'b0, 2'h2, 8'h24, 5'h1F));
		busAccess(1'b1, ECR_OFS_STATUS, 32'h80002001);
		irqExpect(1'b1);
		busAccess(1'b1, ECR_OFS_STATUS, 32'h80000801);
		irqExpect(1'b0);
		busAccess(1'b1, ECR_OFS_STATUS, 32'h80000401);
		irqExpect(1'b1);
		i_pipe.setIrq(6'h00);
		repeat (4) @(posedge clk);
		irqExpect(1'b0);
		summarize();
	end

	initial
	begin
		repeat (3000) @(posedge clk);
		failCount++;
		summarize();
	end
endmodule
